// [core/lpw_ctrl.sv]
// low-power mode entry/exit and wake controller with backup registers
// Behaviour
// [RULE_01] stop keeps ram and registers, lowest power
// [RULE_02] stop gates clocks and fast oscillators
// [RULE_03] peripheral may re-enable hsi in stop
// [RULE_04] regulator low-power, not off, in stop
// [RULE_05] event line wakes stop, core within 3.5us
// [RULE_06] gpio or supply detector feed event lines
// [RULE_07] comparators wake only with reference on
// [RULE_08] serial, i2c, lp timer events wake stop
// [RULE_09] standby powers off regulator and fast oscillators
// [RULE_10] standby with rtc keeps a slow oscillator
// [RULE_11] standby loses core state except always-on
// [RULE_12] standby with rtc exit sources listed
// [RULE_13] standby exit completes within 60us
// [RULE_14] standby without rtc stops every oscillator
// [RULE_15] standby without rtc: reset or wake pin
// [RULE_16] entry never halts rtc or watchdog clocks; here lsi and lse stop in stop and standby when rtc_enable is low, lsi also when rtc_use_lse is high
// [RULE_17] five 32-bit backup registers
// [RULE_18] backup survives system reset and standby
// [RULE_19] rtc and backup powered in all modes
// [RULE_20] rtc alarms, wakeup, tamper, timestamp wake
// [RULE_21] standby exit restarts core via reset
`timescale 1ns/10ps
module lpw_ctrl #(
  parameter int unsigned NUM_BKP = lpw_pkg::NUM_BKP,
  parameter int unsigned BKP_W = lpw_pkg::BKP_W,
  parameter int unsigned STBY_EXIT_CYC = lpw_pkg::STBY_EXIT_CYC
) (
  input wire logic clock,
  input wire logic external_reset_pin,
  input wire logic enter_stop,
  input wire logic enter_standby,
  input wire logic rtc_enable,
  input wire logic rtc_use_lse,
  input wire logic vref_on,
  input wire logic [15:0] gpio_event,
  input wire logic supply_level_detector,
  input wire logic comp1_event,
  input wire logic comp2_event,
  input wire logic usart_wake,
  input wire logic i2c_wake,
  input wire logic lowpower_serial_port_wake,
  input wire logic lowpower_timer_wake,
  input wire logic hsi_request,
  input wire logic [2:0] wake_pin,
  input wire logic external_reset_pin_n,
  input wire logic independent_watchdog_reset,
  input wire logic rtc_alarm_a,
  input wire logic rtc_alarm_b,
  input wire logic rtc_periodic,
  input wire logic rtc_tamper,
  input wire logic rtc_timestamp,
  input wire logic bkp_we,
  input wire logic [2:0] bkp_sel,
  input wire logic [31:0] bkp_wdata,
  output logic [31:0] bkp_rdata,
  output logic core_clk_en,
  output logic pll_en,
  output logic msi_en,
  output logic hsi_en,
  output logic hse_en,
  output logic lsi_en,
  output logic lse_en,
  output logic reg_low_power,
  output logic reg_on,
  output logic core_reset_n,
  output logic cpu_wake,
  output logic in_stop,
  output logic in_standby,
  output logic [4:0] wake_source
);

  //////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for pins and asynchronous wake sources
  localparam int unsigned SW = 21;
  logic [SW-1:0] raw;
  logic [SW-1:0] s1;
  logic [SW-1:0] s2;
  logic [SW-1:0] next_s1;
  logic [SW-1:0] next_s2;
  logic [2:0] pin_prev;
  logic [2:0] next_pin_prev;

  assign raw = {gpio_event, wake_pin, ~external_reset_pin_n,
                independent_watchdog_reset};

  always_comb begin
    next_s1 = raw;
    next_s2 = s1;
    next_pin_prev = s2[4:2];
    if (!external_reset_pin) begin
      next_s1 = '0;
      next_s2 = '0;
      next_pin_prev = '0;
    end
  end

  always_ff @(posedge clock) begin
    s1 <= next_s1;
    s2 <= next_s2;
    pin_prev <= next_pin_prev;
  end

  // other event sources come from on-chip logic on this clock
  logic ev_line;
  logic pin_rise;
  logic rtc_ev;
  logic stop_wake;
  logic stby_wake;
  logic [4:0] src_now;

  always_comb begin
    // gpio or supply detector drive event lines, see [RULE_06]
    ev_line = (|s2[20:5]) | supply_level_detector;
    // comparators gated by the reference, see [RULE_07]
    ev_line = ev_line | (vref_on & (comp1_event | comp2_event));
    // serial and timer wake events, see [RULE_08]
    ev_line = ev_line | usart_wake | i2c_wake
              | lowpower_serial_port_wake | lowpower_timer_wake;
    pin_rise = |(s2[4:2] & ~pin_prev);
    // rtc alarm, periodic, tamper, timestamp, see [RULE_20]
    rtc_ev = rtc_alarm_a | rtc_alarm_b | rtc_periodic
             | rtc_tamper | rtc_timestamp;
    stop_wake = ev_line | rtc_ev; // see [RULE_05]
    // rtc sources count only with rtc active, see [RULE_12] [RULE_15]
    stby_wake = pin_rise | s2[1] | s2[0] | (rtc_enable & rtc_ev);
    src_now = '0;
    if (ev_line) src_now = src_now | lpw_pkg::SRC_EVT;
    if (pin_rise) src_now = src_now | lpw_pkg::SRC_PIN;
    if (rtc_ev) src_now = src_now | lpw_pkg::SRC_RTC;
    if (s2[0]) src_now = src_now | lpw_pkg::SRC_WDG;
    if (s2[1]) src_now = src_now | lpw_pkg::SRC_RST;
  end

  //////////////////////////////////////////////////////////////////////////
  // mode state machine
  lpw_pkg::lpw_state_t state;
  lpw_pkg::lpw_state_t next_state;
  logic [lpw_pkg::CNT_W-1:0] cnt;
  logic [lpw_pkg::CNT_W-1:0] next_cnt;
  logic [4:0] next_wake_source;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wake_source = wake_source;
    case (state)
      lpw_pkg::ST_RUN: begin
        if (enter_standby) begin
          next_state = lpw_pkg::ST_STBY;
        end else if (enter_stop) begin
          next_state = lpw_pkg::ST_STOP;
        end
      end
      lpw_pkg::ST_STOP: begin
        if (s2[1] | s2[0]) begin
          // a reset in stop restarts the core like a standby exit
          next_state = lpw_pkg::ST_CORE_RST;
          next_cnt = lpw_pkg::CNT_W'(lpw_pkg::CORE_RST_CYC - 1);
          next_wake_source = src_now;
        end else if (stop_wake) begin // see [RULE_05]
          next_state = lpw_pkg::ST_STOP_WAKE;
          next_cnt = lpw_pkg::CNT_W'(lpw_pkg::STOP_WAKE_CYC - 1);
          next_wake_source = src_now;
        end
      end
      lpw_pkg::ST_STOP_WAKE: begin
        // clocks restart; core wakes when the count runs out
        if (cnt == '0) begin
          next_state = lpw_pkg::ST_RUN;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      lpw_pkg::ST_STBY: begin
        if (stby_wake) begin // see [RULE_12] [RULE_15]
          next_state = lpw_pkg::ST_STBY_EXIT;
          next_cnt = lpw_pkg::CNT_W'(STBY_EXIT_CYC - lpw_pkg::CORE_RST_CYC
                                     - 2);
          next_wake_source = src_now;
        end
      end
      lpw_pkg::ST_STBY_EXIT: begin
        // regulator ramps up, then core reset, all inside 60us, see [RULE_13]
        if (cnt == '0) begin
          next_state = lpw_pkg::ST_CORE_RST;
          next_cnt = lpw_pkg::CNT_W'(lpw_pkg::CORE_RST_CYC - 1);
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      lpw_pkg::ST_CORE_RST: begin
        if (cnt == '0) begin
          next_state = lpw_pkg::ST_RUN; // see [RULE_21]
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = lpw_pkg::ST_RUN;
      end
    endcase
    if (!external_reset_pin) begin
      next_state = lpw_pkg::ST_RUN;
      next_cnt = '0;
      next_wake_source = '0;
    end
  end

  always_ff @(posedge clock) begin
    state <= next_state;
    cnt <= next_cnt;
    wake_source <= next_wake_source;
  end

  //////////////////////////////////////////////////////////////////////////
  // power and clock controls, registered
  logic next_core_clk_en;
  logic next_fast_en;
  logic next_hsi_en;
  logic next_lsi_en;
  logic next_lse_en;
  logic next_reg_low_power;
  logic next_reg_on;
  logic next_core_reset_n;
  logic next_cpu_wake;
  logic stop_like;
  logic stby_like;

  always_comb begin
    stop_like = (state == lpw_pkg::ST_STOP);
    stby_like = (state == lpw_pkg::ST_STBY)
                | (state == lpw_pkg::ST_STBY_EXIT);
    // core state held in stop since supply stays up, see [RULE_01]
    next_core_clk_en = ~stop_like & ~stby_like; // see [RULE_02]
    next_fast_en = ~stop_like & ~stby_like; // see [RULE_02] [RULE_09]
    // wake-capable peripheral may ask for hsi in stop, see [RULE_03]
    next_hsi_en = next_fast_en | (stop_like & hsi_request);
    // only the slow oscillator the rtc uses keeps running for an active rtc, see [RULE_10]
    // [RULE_16]
    if (stby_like | stop_like) begin
      next_lse_en = rtc_enable & rtc_use_lse; // see [RULE_14]
      next_lsi_en = rtc_enable & ~rtc_use_lse;
    end else begin
      next_lse_en = rtc_use_lse;
      next_lsi_en = 1'b1;
    end
    next_reg_low_power = stop_like; // see [RULE_04]
    next_reg_on = (state != lpw_pkg::ST_STBY); // see [RULE_09]
    // core held in reset while unpowered and after, see [RULE_11] [RULE_21]
    next_core_reset_n = ~stby_like & (state != lpw_pkg::ST_CORE_RST);
    next_cpu_wake = (state == lpw_pkg::ST_STOP_WAKE) & (cnt == '0);
    if (!external_reset_pin) begin
      next_core_clk_en = 1'b1;
      next_fast_en = 1'b1;
      next_hsi_en = 1'b1;
      next_lsi_en = 1'b1;
      next_lse_en = 1'b0;
      next_reg_low_power = 1'b0;
      next_reg_on = 1'b1;
      next_core_reset_n = 1'b0;
      next_cpu_wake = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    core_clk_en <= next_core_clk_en;
    pll_en <= next_fast_en;
    msi_en <= next_fast_en;
    hse_en <= next_fast_en;
    hsi_en <= next_hsi_en;
    lsi_en <= next_lsi_en;
    lse_en <= next_lse_en;
    reg_low_power <= next_reg_low_power;
    reg_on <= next_reg_on;
    core_reset_n <= next_core_reset_n;
    cpu_wake <= next_cpu_wake;
    in_stop <= stop_like & external_reset_pin;
    in_standby <= stby_like & external_reset_pin;
  end

  //////////////////////////////////////////////////////////////////////////
  // backup registers: always-on, untouched by external_reset_pin, see [RULE_17] [RULE_18]
  // writes only while the core is up; contents powered always, see [RULE_19]
  logic [BKP_W-1:0] bkp [NUM_BKP];
  logic [31:0] next_bkp_rdata;

  generate
    for (genvar i = 0; i < NUM_BKP; i++) begin : g_bkp
      logic [BKP_W-1:0] next_word;
      always_comb begin
        next_word = bkp[i];
        if (bkp_we && core_reset_n && (bkp_sel == 3'(i))) begin
          next_word = bkp_wdata[BKP_W-1:0];
        end
      end
      always_ff @(posedge clock) begin
        bkp[i] <= next_word;
      end
    end
  endgenerate

  always_comb begin
    next_bkp_rdata = lpw_pkg::BKP_RST;
    if (32'(bkp_sel) < NUM_BKP) begin
      next_bkp_rdata = 32'(bkp[bkp_sel]);
    end
  end

  always_ff @(posedge clock) begin
    bkp_rdata <= next_bkp_rdata;
  end

endmodule // lpw_ctrl

// [core/lpw_pkg.sv]
// constants for the low-power mode and wake controller
package lpw_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned STOP_WAKE_NS = 3500;
  localparam int unsigned STBY_EXIT_NS = 60000;
  // longest times round down
  localparam int unsigned STOP_WAKE_CYC = STOP_WAKE_NS / 25;
  localparam int unsigned STBY_EXIT_CYC = STBY_EXIT_NS / 25;
  localparam int unsigned CORE_RST_CYC = 16;
  localparam int unsigned NUM_BKP = 5;
  localparam int unsigned BKP_W = 32;
  localparam int unsigned NUM_WAKE_PINS = 3;
  localparam int unsigned EVT_W = 29;
  localparam int unsigned CNT_W = 12;
  localparam logic [31:0] BKP_RST = 32'h00000000;
  // wake source bits in status
  localparam int unsigned SRC_W = 5;
  localparam logic [4:0] SRC_EVT = 5'h01;
  localparam logic [4:0] SRC_PIN = 5'h02;
  localparam logic [4:0] SRC_RTC = 5'h04;
  localparam logic [4:0] SRC_WDG = 5'h08;
  localparam logic [4:0] SRC_RST = 5'h10;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_STOP = 3'b001,
    ST_STOP_WAKE = 3'b010,
    ST_STBY = 3'b011,
    ST_STBY_EXIT = 3'b100,
    ST_CORE_RST = 3'b101
  } lpw_state_t;
endpackage

// [tb/lpw_ctrl_sva.sv]
// assertion checker on the ports of the low-power controller
`timescale 1ns/10ps
module lpw_ctrl_chk #(
  parameter int unsigned STBY_EXIT_CYC = 2400
) (
  input wire logic clock,
  input wire logic external_reset_pin,
  input wire logic rtc_enable,
  input wire logic hsi_request,
  input wire logic [15:0] gpio_event,
  input wire logic [2:0] wake_pin,
  input wire logic [2:0] bkp_sel,
  input wire logic [31:0] bkp_rdata,
  input wire logic core_clk_en,
  input wire logic pll_en,
  input wire logic msi_en,
  input wire logic hsi_en,
  input wire logic hse_en,
  input wire logic lsi_en,
  input wire logic lse_en,
  input wire logic reg_low_power,
  input wire logic reg_on,
  input wire logic core_reset_n,
  input wire logic cpu_wake,
  input wire logic in_stop,
  input wire logic in_standby
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!external_reset_pin);
  logic [15:0] exit_cnt;
  logic [2:0] pin_q;
  logic exiting;
  ////////////////////////////////////////////////////////////
  // exit timer: wake pin edge in standby until core leaves reset
  always_ff @(posedge clock) begin
    pin_q <= wake_pin;
    if (!external_reset_pin || core_reset_n) begin
      exiting <= 1'b0;
      exit_cnt <= 16'h0000;
    end else if (exiting) begin
      exit_cnt <= exit_cnt + 16'h0001;
    end else if (in_standby && (wake_pin & ~pin_q) != 3'h0) begin
      exiting <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////
  stop_clocks_a: assert property (
    in_stop |-> !core_clk_en && !pll_en && !msi_en && !hse_en)
    else $error("clock running in stop");
  stop_reg_a: assert property (
    in_stop |-> reg_on && reg_low_power) else $error("stop regulator");
  hsi_keep_a: assert property (
    in_stop && hsi_request |-> ##[0:2] hsi_en) else $error("hsi refused");
  // sync stages add a few cycles to the wake delay
  stop_wake_a: assert property (
    in_stop && gpio_event != 16'h0000 |-> ##[1:150] cpu_wake)
    else $error("stop wake late");
  stby_off_a: assert property (
    $rose(in_standby) |-> !reg_on && !pll_en && !msi_en && !hse_en
    && !hsi_en && !core_reset_n) else $error("standby left powered");
  stby_slow_a: assert property (
    $rose(in_standby) && rtc_enable |-> lsi_en || lse_en)
    else $error("rtc clock lost");
  stby_dark_a: assert property (
    $rose(in_standby) && !rtc_enable |-> !lsi_en && !lse_en)
    else $error("oscillator left on");
  stby_exit_a: assert property (
    exit_cnt <= 16'(STBY_EXIT_CYC + 4)) else $error("standby exit late");
  bkp_void_a: assert property (
    bkp_sel > 3'h4 |=> bkp_rdata == 32'h00000000)
    else $error("backup beyond five");
  cover property ($rose(cpu_wake));
  cover property ($rose(in_standby) && !rtc_enable);
  cover property (exiting && exit_cnt > 16'h0010);
endmodule // lpw_ctrl_chk

bind lpw_ctrl lpw_ctrl_chk #(.STBY_EXIT_CYC(STBY_EXIT_CYC)) i_chk (
  .clock(clock), .external_reset_pin(external_reset_pin), .rtc_enable(rtc_enable),
  .hsi_request(hsi_request), .gpio_event(gpio_event),
  .wake_pin(wake_pin), .bkp_sel(bkp_sel), .bkp_rdata(bkp_rdata),
  .core_clk_en(core_clk_en), .pll_en(pll_en), .msi_en(msi_en),
  .hsi_en(hsi_en), .hse_en(hse_en), .lsi_en(lsi_en), .lse_en(lse_en),
  .reg_low_power(reg_low_power), .reg_on(reg_on),
  .core_reset_n(core_reset_n), .cpu_wake(cpu_wake),
  .in_stop(in_stop), .in_standby(in_standby));

// [tb/lpw_wake_src.sv]
// model of the wake-capable peripherals and pins
`timescale 1ns/10ps
module lpw_wake_src (
  input wire logic clock,
  input wire logic go,
  input wire logic [3:0] sel,
  output logic [15:0] src
);
  logic [2:0] hold = 3'h0;
  initial src = 16'h0000;
  // one source raised four cycles so the syncs catch it, then idle
  always @(negedge clock) begin
    if (go) begin
      src <= 16'h0001 << sel;
      hold <= 3'h4;
    end else if (hold > 3'h1) begin
      hold <= hold - 3'h1;
    end else begin
      src <= 16'h0000;
      hold <= 3'h0;
    end
  end
endmodule // lpw_wake_src

// [tb/lpw_ctrl_tb_top.sv]
// self-checking bench for the low-power controller
`timescale 1ns/10ps
module lpw_ctrl_tb_top;
  logic clock = 1'b0, external_reset_pin = 1'b0, stp = 1'b0, sby = 1'b0, rtc = 1'b1;
  logic low_speed_crystal_osc = 1'b0, vref = 1'b1, hsi_rq = 1'b0, go = 1'b0, we = 1'b0;
  logic rd = 1'b0, cw, crn, ist, isb, crn_q = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [15:0] src, gm = 16'h0001;
  logic [2:0] pm = 3'h1, bsel = 3'h0;
  logic [31:0] wd = 32'h0, rdata;
  logic [31:0] bm [5];
  logic [4:0] wsrc;
  logic [4:0] wq[$];
  logic [31:0] bq[$];
  int failures = 0, num_checks = 0, seen = 0;
  initial forever #12.5 clock = ~clock;
  lpw_wake_src i_lpw_wake_src (.clock(clock), .go(go), .sel(sel),
    .src(src));
  lpw_ctrl #(.STBY_EXIT_CYC(40)) i_lpw_ctrl (.clock(clock), .external_reset_pin(external_reset_pin),
    .enter_stop(stp), .enter_standby(sby), .rtc_enable(rtc),
    .rtc_use_lse(low_speed_crystal_osc), .vref_on(vref), .gpio_event(src[0] ? gm : 16'h0),
    .supply_level_detector(src[1]), .comp1_event(src[2]),
    .comp2_event(src[3]), .usart_wake(src[4]), .i2c_wake(src[5]),
    .lowpower_serial_port_wake(src[6]), .lowpower_timer_wake(src[7]),
    .hsi_request(hsi_rq), .wake_pin(src[13] ? pm : 3'h0),
    .external_reset_pin_n(~src[15]), .independent_watchdog_reset(src[14]),
    .rtc_alarm_a(src[8]), .rtc_alarm_b(src[9]), .rtc_periodic(src[10]),
    .rtc_tamper(src[11]), .rtc_timestamp(src[12]), .bkp_we(we),
    .bkp_sel(bsel), .bkp_wdata(wd), .bkp_rdata(rdata), .core_clk_en(),
    .pll_en(), .msi_en(), .hsi_en(), .hse_en(), .lsi_en(), .lse_en(),
    .reg_low_power(), .reg_on(), .core_reset_n(crn), .cpu_wake(cw),
    .in_stop(ist), .in_standby(isb), .wake_source(wsrc));
  ////////////////////////////////////////////////////////////
  task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // bounded wait: kind 0 for a low-power mode, 1 for a result count
  task automatic tick_until(input int kind, input int n);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(negedge clock);
      if (kind == 0 && (ist === 1'b1 || isb === 1'b1)) break;
      if (kind == 1 && seen == n) break;
    end
    if (i == 3000) begin
      failures++;
      test_done();
    end
  endtask
  // result watcher: a wake pulse or a released core reset ends an exit
  always @(posedge clock) begin
    crn_q <= crn;
    if (cw === 1'b1 || (crn === 1'b1 && crn_q === 1'b0)) begin
      seen++;
      check("wake_source", 32'(wsrc), wq.size() ? 32'(wq.pop_front())
        : 32'hffffffff);
    end
    if (rd) check("bkp_rdata", rdata, bq.pop_front());
  end
  ////////////////////////////////////////////////////////////
  task automatic bio(input int s, input logic w, input logic [31:0] d);
    @(negedge clock);
    bsel = 3'(s);
    wd = d;
    we = w;
    if (!w) bq.push_back(d);
    @(negedge clock);
    we = 1'b0;
    rd = !w;
    @(negedge clock);
    rd = 1'b0;
  endtask
  task automatic enter(input logic deep);
    @(negedge clock);
    low_speed_crystal_osc = 1'($urandom_range(1, 0));
    gm = 16'($urandom_range(65535, 1));
    pm = 3'h1 << $urandom_range(2, 0);
    if (deep) sby = 1'b1;
    else stp = 1'b1;
    tick_until(0, 0);
    stp = 1'b0;
    sby = 1'b0;
  endtask
  // code zero means the source must be refused and the mode held
  task automatic fire(input int s, input logic [4:0] code);
    int n;
    n = seen;
    if (code != 5'h00) wq.push_back(code);
    sel = 4'(s);
    go <= 1'b1;
    @(negedge clock);
    go <= 1'b0;
    if (code != 5'h00) tick_until(1, n + 1);
    else begin
      repeat (60) @(negedge clock);
      check("asleep", 32'(ist | isb), 32'h1);
    end
  endtask
  function automatic logic [4:0] code_of(input int s);
    if (s < 8) return lpw_pkg::SRC_EVT;
    if (s < 13) return lpw_pkg::SRC_RTC;
    if (s == 13) return lpw_pkg::SRC_PIN;
    return s == 14 ? lpw_pkg::SRC_WDG : lpw_pkg::SRC_RST;
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    int s;
    void'($urandom(32'h5da1));
    wq.push_back(5'h00);
    repeat (16) @(negedge clock);
    external_reset_pin = 1'b1;
    tick_until(1, 1);
    for (s = 0; s < 5; s++) begin
      bm[s] = $urandom();
      bio(s, 1'b1, bm[s]);
    end
    hsi_rq = 1'b1;
    // every stop source, with the pin skipped as it is standby only
    for (s = 0; s < 16; s++) begin
      if (s == 13) continue;
      enter(1'b0);
      fire(s, code_of(s));
      hsi_rq = 1'b0;
    end
    vref = 1'b0;
    enter(1'b0);
    fire(2, 5'h00);
    fire(1, lpw_pkg::SRC_EVT);
    vref = 1'b1;
    for (s = 8; s < 16; s++) begin
      enter(1'b1);
      fire(s, code_of(s));
    end
    rtc = 1'b0;
    enter(1'b1);
    fire(10, 5'h00);
    fire(13, lpw_pkg::SRC_PIN);
    wq.push_back(5'h00);
    @(negedge clock);
    external_reset_pin = 1'b0;
    repeat (16) @(negedge clock);
    external_reset_pin = 1'b1;
    tick_until(1, seen + 1);
    for (s = 0; s < 8; s++) bio(s, 1'b0, s < 5 ? bm[s] : 32'h0);
    test_done();
  end
endmodule // lpw_ctrl_tb_top
